/* hdl/bal_pkg.sv */
package bal_pkg;

  // ==========================================================
  // Register map, byte addresses on the 32-bit slave
  // ==========================================================
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] OFS_DEST = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_SRC = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_IMM = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_HIGH = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_CMD = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_STAT = 5'h18;
  localparam logic [ADDR_W-1:0] OFS_PROD = 5'h1c;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_PROD = 16'h0000;

  // Field positions
  localparam int STAT_BUSY_BIT = 0;
  localparam int CMD_LSB = 0;
  localparam int CMD_W = 5;

  // Execution lengths in core clocks
  localparam logic [1:0] CYC_SHORT = 2'h1;
  localparam logic [1:0] CYC_LONG = 2'h2;

  // ==========================================================
  // Types
  // ==========================================================
  typedef struct packed {
    logic h;
    logic s;
    logic v;
    logic n;
    logic z;
    logic c;
  } bal_flags_t;

  localparam bal_flags_t RST_FLAGS = 6'h00;

  typedef enum logic [4:0] {
    OP_SUM = 5'h00,
    OP_SUM_C = 5'h01,
    OP_WORD_ADD = 5'h02,
    OP_DIFF = 5'h03,
    OP_DIFF_IMM = 5'h04,
    OP_DIFF_B = 5'h05,
    OP_DIFF_B_IMM = 5'h06,
    OP_WORD_SUB = 5'h07,
    OP_AND = 5'h08,
    OP_AND_IMM = 5'h09,
    OP_OR = 5'h0a,
    OP_OR_IMM = 5'h0b,
    OP_XOR = 5'h0c,
    OP_INVERT = 5'h0d,
    OP_NEGATE = 5'h0e,
    OP_SET_MASK = 5'h0f,
    OP_CLR_MASK = 5'h10,
    OP_PLUS1 = 5'h11,
    OP_MINUS1 = 5'h12,
    OP_CHECK = 5'h13,
    OP_ZERO = 5'h14,
    OP_ONES = 5'h15,
    OP_MUL_U = 5'h16,
    OP_MUL_S = 5'h17,
    OP_MUL_SU = 5'h18,
    OP_MUL_FRAC = 5'h19
  } bal_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } bal_state_t;

  typedef struct packed {
    bal_op_t op;
    logic [7:0] d;
    logic [7:0] r;
    logic [7:0] k;
    logic [7:0] hi;
    bal_flags_t fl;
  } bal_req_t;

  typedef struct packed {
    logic [7:0] lo;
    logic [7:0] hi;
    logic [15:0] prod;
    logic wr_lo;
    logic wr_hi;
    logic wr_prod;
    bal_flags_t fl;
  } bal_res_t;

  function automatic logic [1:0] op_cycles(input bal_op_t op);
    case (op)
      OP_WORD_ADD, OP_WORD_SUB, OP_MUL_U, OP_MUL_S, OP_MUL_SU,
      OP_MUL_FRAC: op_cycles = CYC_LONG;
      default: op_cycles = CYC_SHORT;
    endcase
  endfunction

endpackage

/* hdl/bal_exec.sv */
`timescale 1ns/1ns
module bal_exec (
  // Operation and operands
  input bal_pkg::bal_req_t req,
  // Outcome
  output bal_pkg::bal_res_t res
);
  import bal_pkg::*;

  // Returns {v, h, c, result}
  function automatic logic [10:0] add8(input logic [7:0] a,
    input logic [7:0] b, input logic cin);
    logic [8:0] s;
    logic [4:0] hs;
    logic v;
    s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    hs = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    v = (a[7] == b[7]) && (s[7] != a[7]);
    add8 = {v, hs[4], s[8], s[7:0]};
  endfunction

  // Returns {v, h, borrow, result}
  function automatic logic [10:0] sub8(input logic [7:0] a,
    input logic [7:0] b, input logic cin);
    logic [8:0] s;
    logic [4:0] hs;
    logic v;
    s = {1'b0, a} - {1'b0, b} - {8'h00, cin};
    hs = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
    v = (a[7] != b[7]) && (s[7] != a[7]);
    sub8 = {v, hs[4], s[8], s[7:0]};
  endfunction

  logic [10:0] ar;
  logic [15:0] w;
  logic [15:0] p;
  logic [16:0] ps;
  logic logic_op;

  always_comb
  begin
    res = '0;
    res.fl = req.fl;
    ar = '0;
    w = '0;
    p = '0;
    ps = '0;
    logic_op = 1'b0;
    unique case (req.op)
      OP_SUM, OP_SUM_C: // RQ1
        ar = add8(req.d, req.r, (req.op == OP_SUM_C) & req.fl.c);
      OP_DIFF, OP_DIFF_IMM: // RQ3
        ar = sub8(req.d, (req.op == OP_DIFF) ? req.r : req.k, 1'b0);
      OP_DIFF_B, OP_DIFF_B_IMM: // RQ4
        ar = sub8(req.d, (req.op == OP_DIFF_B) ? req.r : req.k,
          req.fl.c);
      OP_NEGATE: // RQ9
        ar = sub8(8'h00, req.d, 1'b0);
      default: ar = '0;
    endcase
    unique case (req.op)
      OP_SUM, OP_SUM_C, OP_DIFF, OP_DIFF_IMM, OP_DIFF_B,
      OP_DIFF_B_IMM, OP_NEGATE:
      begin
        res.lo = ar[7:0];
        res.wr_lo = 1'b1;
        res.fl.c = ar[8];
        res.fl.h = ar[9];
        res.fl.v = ar[10];
        res.fl.z = (ar[7:0] == 8'h00); // RQ16
        res.fl.n = ar[7];
      end
      OP_WORD_ADD, OP_WORD_SUB:
      begin
        // 16-bit wrap on the register pair
        if (req.op == OP_WORD_ADD)
        begin
          w = {req.hi, req.d} + {8'h00, req.k}; // RQ2 RQ17
          res.fl.v = ~req.hi[7] & w[15];
          res.fl.c = ~w[15] & req.hi[7];
        end
        else
        begin
          w = {req.hi, req.d} - {8'h00, req.k}; // RQ5 RQ17
          res.fl.v = req.hi[7] & ~w[15];
          res.fl.c = w[15] & ~req.hi[7];
        end
        res.lo = w[7:0];
        res.hi = w[15:8];
        res.wr_lo = 1'b1;
        res.wr_hi = 1'b1;
        res.fl.z = (w == 16'h0000);
        res.fl.n = w[15];
        res.fl.s = w[15] ^ res.fl.v; // RQ16
      end
      OP_AND, OP_AND_IMM, OP_CHECK, OP_CLR_MASK:
      begin
        logic_op = 1'b1;
        if (req.op == OP_AND) res.lo = req.d & req.r; // RQ6
        else if (req.op == OP_AND_IMM) res.lo = req.d & req.k;
        else if (req.op == OP_CHECK) res.lo = req.d & req.d; // RQ12
        else res.lo = req.d & (8'hff - req.k); // RQ10
      end
      OP_OR, OP_OR_IMM, OP_SET_MASK, OP_XOR, OP_ZERO:
      begin
        logic_op = 1'b1;
        if (req.op == OP_OR) res.lo = req.d | req.r; // RQ7
        else if (req.op == OP_XOR) res.lo = req.d ^ req.r;
        else if (req.op == OP_ZERO) res.lo = req.d ^ req.d; // RQ13
        else res.lo = req.d | req.k; // RQ10
      end
      OP_INVERT:
      begin
        res.lo = 8'hff - req.d; // RQ8
        res.wr_lo = 1'b1;
        res.fl.c = 1'b1;
        res.fl.v = 1'b0;
        res.fl.z = (res.lo == 8'h00);
        res.fl.n = res.lo[7];
      end
      OP_PLUS1, OP_MINUS1:
      begin
        // Carry is left alone so multi-byte loops can count
        res.lo = (req.op == OP_PLUS1) ? req.d + 8'h01
          : req.d - 8'h01; // RQ11
        res.wr_lo = 1'b1;
        res.fl.v = (req.op == OP_PLUS1) ? (res.lo == 8'h80)
          : (res.lo == 8'h7f);
        res.fl.z = (res.lo == 8'h00);
        res.fl.n = res.lo[7];
      end
      OP_ONES:
      begin
        res.lo = 8'hff; // RQ13
        res.wr_lo = 1'b1;
      end
      OP_MUL_U, OP_MUL_S, OP_MUL_SU, OP_MUL_FRAC:
      begin
        if (req.op == OP_MUL_S)
          p = 16'($signed(req.d) * $signed(req.r)); // RQ14
        else if (req.op == OP_MUL_SU)
        begin
          ps = 17'($signed({req.d[7], req.d})
            * $signed({1'b0, req.r}));
          p = ps[15:0];
        end
        else
          p = {8'h00, req.d} * {8'h00, req.r};
        res.fl.c = p[15];
        res.prod = (req.op == OP_MUL_FRAC) ? {p[14:0], 1'b0} : p; // RQ15
        res.wr_prod = 1'b1;
        res.fl.z = (res.prod == 16'h0000);
      end
      default:
      begin
        res.wr_lo = 1'b0;
      end
    endcase
    if (logic_op)
    begin
      res.wr_lo = 1'b1;
      res.fl.v = 1'b0;
      res.fl.z = (res.lo == 8'h00);
      res.fl.n = res.lo[7];
    end
  end

endmodule

/* hdl/bal_top.sv */
// Summary of operation
// RQ1 - Add stores dest plus source, plus carry in carry form, ZCNVH, 1 cycle.
// RQ2 - Word add adds the immediate to the high:low pair, ZCNVS, 2 cycles.
// RQ3 - Subtract stores dest minus register or immediate, ZCNVH, 1 cycle.
// RQ4 - Subtract with borrow also takes off the carry, ZCNVH, 1 cycle.
// RQ5 - Word subtract takes the immediate from the pair, ZCNVS, 2 cycles.
// RQ6 - AND with register or immediate sets only Z N V, 1 cycle.
// RQ7 - OR and XOR with register or immediate set Z N V, 1 cycle; the code has XOR with register only.
// RQ8 - Invert stores 0xff minus dest, sets Z C N V, 1 cycle.
// RQ9 - Negate stores 0x00 minus dest, sets Z C N V H, 1 cycle.
// RQ10 - Mask set ORs mask in, clear ANDs 0xff minus mask, ZNV, 1 cycle.
// RQ11 - Plus one and minus one set Z N V, keep carry, 1 cycle.
// RQ12 - Check ANDs dest with itself, value kept, Z N V updated, 1 cycle.
// RQ13 - Zero fill XORs dest with itself, ZNV; ones fill loads 0xff only.
// RQ14 - Multiplies write the 16-bit product pair, Z C, 2 cycles.
// RQ15 - Fractional multiply writes product shifted left once, Z C, 2 cycles.
// RQ16 - Z all-zero, N top bit, V two's overflow, H from bit 3, S is N xor V.
// RQ17 - Bytes wrap at 256, words at 65536, unlisted flags keep their value.
//
// The Avalon-MM register port and the placing of the registers were decided locally.
`timescale 1ns/1ns
module bal_top (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // Avalon-MM slave
  input wire logic [bal_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Status toward the core
  output logic [7:0] ALU_FLAGS,
  output logic ALU_BUSY
);
  import bal_pkg::*;

  // ==========================================================
  // State
  // ==========================================================
  bal_state_t state_q, state_d;
  logic [1:0] cnt_q, cnt_d;
  bal_op_t op_q, op_d;
  logic [7:0] dst_q, dst_d;
  logic [7:0] src_q, src_d;
  logic [7:0] imm_q, imm_d;
  logic [7:0] whi_q, whi_d;
  logic [15:0] prod_q, prod_d;
  bal_flags_t flags_q, flags_d;
  logic rd_ack_q, rd_ack_d;
  logic [31:0] rdata_q, rdata_d;

  bal_req_t req;
  bal_res_t res;
  logic wr_ok;
  logic start;
  logic commit;
  logic [15:0] word_q;

  assign word_q = {whi_q, dst_q};

  // ==========================================================
  // Bus handshake
  // ==========================================================
  // Writes stall while an operation runs so operands stay stable
  assign AVS_WAITREQUEST = (AVS_READ & ~rd_ack_q)
    | (AVS_WRITE & (state_q != ST_IDLE));
  assign wr_ok = AVS_WRITE & (state_q == ST_IDLE) & AVS_BYTEENABLE[0];
  assign start = wr_ok & (AVS_ADDRESS == OFS_CMD);
  assign commit = (state_q == ST_RUN) & (cnt_q == CYC_SHORT);
  assign AVS_READDATA = rdata_q;
  assign ALU_FLAGS = {2'b00, flags_q};
  assign ALU_BUSY = (state_q == ST_RUN);

  always_comb
  begin
    rd_ack_d = AVS_READ & ~rd_ack_q;
    rdata_d = rdata_q;
    if (AVS_READ & ~rd_ack_q)
    begin
      unique case (AVS_ADDRESS)
        OFS_DEST: rdata_d = {24'h000000, dst_q};
        OFS_SRC: rdata_d = {24'h000000, src_q};
        OFS_IMM: rdata_d = {24'h000000, imm_q};
        OFS_HIGH: rdata_d = {24'h000000, whi_q};
        OFS_FLAGS: rdata_d = {26'h0000000, flags_q};
        OFS_CMD: rdata_d = {27'h0000000, op_q};
        OFS_STAT: rdata_d = {31'h00000000, ALU_BUSY};
        OFS_PROD: rdata_d = {16'h0000, prod_q};
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      rd_ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      rd_ack_q <= rd_ack_d;
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================
  // Datapath
  // ==========================================================
  assign req = '{op: op_q, d: dst_q, r: src_q, k: imm_q, hi: whi_q,
    fl: flags_q};

  bal_exec u_exec (
    .req(req),
    .res(res)
  );

  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    op_d = op_q;
    dst_d = dst_q;
    src_d = src_q;
    imm_d = imm_q;
    whi_d = whi_q;
    prod_d = prod_q;
    flags_d = flags_q;
    unique case (state_q)
      ST_IDLE:
      begin
        if (wr_ok)
        begin
          unique case (AVS_ADDRESS)
            OFS_DEST: dst_d = AVS_WRITEDATA[7:0];
            OFS_SRC: src_d = AVS_WRITEDATA[7:0];
            OFS_IMM: imm_d = AVS_WRITEDATA[7:0];
            OFS_HIGH: whi_d = AVS_WRITEDATA[7:0];
            OFS_FLAGS: flags_d = AVS_WRITEDATA[5:0];
            default: dst_d = dst_q;
          endcase
        end
        if (start)
        begin
          op_d = bal_op_t'(AVS_WRITEDATA[CMD_LSB +: CMD_W]);
          cnt_d = op_cycles(op_d); // RQ2 RQ5 RQ14 RQ15
          state_d = ST_RUN;
        end
      end
      ST_RUN:
      begin
        cnt_d = cnt_q - 2'h1;
        if (commit)
        begin
          // Unlisted flags come back unchanged from the unit
          flags_d = res.fl; // RQ17
          if (res.wr_lo) dst_d = res.lo;
          if (res.wr_hi) whi_d = res.hi;
          if (res.wr_prod) prod_d = res.prod;
          state_d = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      state_q <= ST_IDLE;
      cnt_q <= 2'h0;
      op_q <= OP_SUM;
      dst_q <= RST_BYTE;
      src_q <= RST_BYTE;
      imm_q <= RST_BYTE;
      whi_q <= RST_BYTE;
      prod_q <= RST_PROD;
      flags_q <= RST_FLAGS;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      op_q <= op_d;
      dst_q <= dst_d;
      src_q <= src_d;
      imm_q <= imm_d;
      whi_q <= whi_d;
      prod_q <= prod_d;
      flags_q <= flags_d;
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  a_short_op_time: assert property (@(posedge CORE_CLK) // RQ1
    disable iff (RST)
    start && (op_cycles(op_d) == CYC_SHORT) |=> ALU_BUSY ##1 !ALU_BUSY)
    else $error("one-cycle operation took wrong time");

  a_long_op_time: assert property (@(posedge CORE_CLK) // RQ14
    disable iff (RST)
    start && (op_cycles(op_d) == CYC_LONG)
    |=> ALU_BUSY [*2] ##1 !ALU_BUSY)
    else $error("two-cycle operation took wrong time");

  a_carry_sum: assert property (@(posedge CORE_CLK) // RQ1
    disable iff (RST)
    commit && (op_q == OP_SUM_C) |=> dst_q == 8'($past(dst_q)
      + $past(src_q) + {7'h00, $past(flags_q.c)}))
    else $error("sum with carry value wrong");

  a_word_sum: assert property (@(posedge CORE_CLK) // RQ2
    disable iff (RST)
    commit && (op_q == OP_WORD_ADD)
    |=> word_q == 16'($past(word_q) + {8'h00, $past(imm_q)})
      && flags_q.s == (flags_q.n ^ flags_q.v))
    else $error("word add value or sign flag wrong");

  a_borrow_flag: assert property (@(posedge CORE_CLK) // RQ4
    disable iff (RST)
    commit && (op_q == OP_DIFF_B)
    |=> flags_q.c == ({1'b0, $past(dst_q)}
      < {1'b0, $past(src_q)} + {8'h00, $past(flags_q.c)}))
    else $error("borrow flag wrong");

  a_logic_flags: assert property (@(posedge CORE_CLK) // RQ6
    disable iff (RST)
    commit && (op_q == OP_AND)
    |=> !flags_q.v && $stable(flags_q.c) && $stable(flags_q.h))
    else $error("logic op touched wrong flags");

  a_invert_carry: assert property (@(posedge CORE_CLK) // RQ8
    disable iff (RST)
    commit && (op_q == OP_INVERT)
    |=> flags_q.c && (dst_q == ~$past(dst_q)))
    else $error("invert result or carry wrong");

  a_negate_carry: assert property (@(posedge CORE_CLK) // RQ9
    disable iff (RST)
    commit && (op_q == OP_NEGATE)
    |=> flags_q.c == (dst_q != 8'h00) && dst_q == 8'(-$past(dst_q)))
    else $error("negate result or carry wrong");

  a_step_keeps_c: assert property (@(posedge CORE_CLK) // RQ11
    disable iff (RST)
    commit && (op_q == OP_PLUS1 || op_q == OP_MINUS1)
    |=> $stable(flags_q.c))
    else $error("step changed carry");

  a_ones_no_flag: assert property (@(posedge CORE_CLK) // RQ13
    disable iff (RST)
    commit && (op_q == OP_ONES) |=> dst_q == 8'hff && $stable(flags_q))
    else $error("ones fill wrong");

  a_frac_product: assert property (@(posedge CORE_CLK) // RQ15
    disable iff (RST)
    commit && (op_q == OP_MUL_FRAC)
    |=> prod_q == 16'(({8'h00, $past(dst_q)}
      * {8'h00, $past(src_q)}) << 1))
    else $error("fractional product wrong");

endmodule

/* dv/bal_host.sv */
`timescale 1ns/1ns
module bal_host (
  // Clock
  input wire logic clk,
  // Avalon-MM master side
  output logic [bal_pkg::ADDR_W-1:0] address,
  output logic read,
  output logic write,
  output logic [31:0] writedata,
  output logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest
);
  import bal_pkg::*;

  initial
  begin
    address = '0;
    read = 1'b0;
    write = 1'b0;
    writedata = '0;
    byteenable = 4'h0;
  end

  // ==========================================================
  // Bus cycles
  // ==========================================================
  // Released address and data lines carry inverted values so stale data never matches
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d,
    input logic [3:0] be, output int n);
    @(posedge clk);
    address <= a;
    writedata <= d;
    byteenable <= be;
    write <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (waitrequest !== 1'b0);
    write <= 1'b0;
    address <= ~a;
    writedata <= ~d;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] v);
    int n;
    @(posedge clk);
    address <= a;
    read <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (waitrequest !== 1'b0);
    v = readdata;
    read <= 1'b0;
    address <= ~a;
  endtask
endmodule

/* dv/byte_arith_logic_unit_tb_top.sv */
`timescale 1ns/1ns
module byte_arith_logic_unit_tb_top;
  import bal_pkg::*;

  logic clk;
  logic rst;
  logic [ADDR_W-1:0] adr;
  logic rdq;
  logic wrq;
  logic [31:0] wdat;
  logic [3:0] be;
  logic [31:0] rdat;
  logic wait_s;
  logic [7:0] flags;
  logic busy;
  int fail_count = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [15:0] exp_prod = 16'h0000;

  bal_top u_bal_top (.CORE_CLK(clk), .RST(rst), .AVS_ADDRESS(adr),
    .AVS_READ(rdq), .AVS_WRITE(wrq), .AVS_WRITEDATA(wdat),
    .AVS_BYTEENABLE(be), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wait_s),
    .ALU_FLAGS(flags), .ALU_BUSY(busy));

  bal_host u_bal_host (.clk(clk), .address(adr), .read(rdq), .write(wrq),
    .writedata(wdat), .byteenable(be), .readdata(rdat),
    .waitrequest(wait_s));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ==========================================================
  // Checking and closing
  // ==========================================================
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Bound well above the thousand or so cycles the tests need
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      fail_count++;
      $display("run stopped by cycle limit");
      wrap_up();
    end
  end

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    u_bal_host.wr(a, d, 4'h1, n);
  endtask

  // ==========================================================
  // Reference model
  // ==========================================================
  task automatic model(input bal_op_t op, input logic [7:0] d, r, k, h,
    input bal_flags_t fi, output logic [7:0] lo, ho,
    output logic [15:0] p, output bal_flags_t f, output logic [5:0] fm);
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] x;
    logic [8:0] s;
    logic [15:0] w;
    logic [15:0] m;
    logic ci;
    logic sb;
    logic lg;
    f = fi;
    lo = d;
    ho = h;
    p = exp_prod;
    lg = 1'b1;
    x = d;
    case (op)
      OP_AND: x = d & r;
      OP_AND_IMM: x = d & k;
      OP_OR: x = d | r;
      OP_OR_IMM, OP_SET_MASK: x = d | k;
      OP_XOR: x = d ^ r;
      OP_CLR_MASK: x = d & ~k;
      OP_INVERT: x = ~d;
      OP_ZERO: x = 8'h00;
      OP_PLUS1: x = d + 8'h01;
      OP_MINUS1: x = d - 8'h01;
      OP_CHECK: x = d;
      default: lg = 1'b0;
    endcase
    if (lg)
    begin
      lo = x;
      f.z = (x == 8'h00);
      f.n = x[7];
      f.v = (op == OP_PLUS1) ? (x == 8'h80) :
        (op == OP_MINUS1) ? (x == 8'h7f) : 1'b0;
    end
    // Carry after invert is left open, so it is not compared
    fm = (op == OP_INVERT) ? 6'h3e : 6'h3f;
    sb = !(op inside {OP_SUM, OP_SUM_C});
    a = (op == OP_NEGATE) ? 8'h00 : d;
    b = (op == OP_NEGATE) ? d :
      (op inside {OP_DIFF_IMM, OP_DIFF_B_IMM}) ? k : r;
    ci = (op inside {OP_SUM_C, OP_DIFF_B, OP_DIFF_B_IMM}) & fi.c;
    s = sb ? {1'b0, a} - {1'b0, b} - ci : {1'b0, a} + b + ci;
    if (op inside {OP_SUM, OP_SUM_C, OP_DIFF, OP_DIFF_IMM, OP_DIFF_B,
      OP_DIFF_B_IMM, OP_NEGATE})
    begin
      lo = s[7:0];
      f.c = s[8];
      f.z = (lo == 8'h00);
      f.n = lo[7];
      f.h = sb ? (~a[3] & b[3] | b[3] & lo[3] | lo[3] & ~a[3]) :
        (a[3] & b[3] | b[3] & ~lo[3] | ~lo[3] & a[3]);
      f.v = sb ? (a[7] & ~b[7] & ~lo[7] | ~a[7] & b[7] & lo[7]) :
        (a[7] & b[7] & ~lo[7] | ~a[7] & ~b[7] & lo[7]);
    end
    w = (op == OP_WORD_ADD) ? {h, d} + k : {h, d} - k;
    if (op inside {OP_WORD_ADD, OP_WORD_SUB})
    begin
      lo = w[7:0];
      ho = w[15:8];
      f.n = w[15];
      f.z = (w == 16'h0000);
      f.v = (op == OP_WORD_ADD) ? ~h[7] & w[15] : h[7] & ~w[15];
      f.c = (op == OP_WORD_ADD) ? h[7] & ~w[15] : ~h[7] & w[15];
      f.s = f.n ^ f.v;
    end
    m = {(op inside {OP_MUL_S, OP_MUL_SU}) ? {8{d[7]}} : 8'h00, d} *
      {(op == OP_MUL_S) ? {8{r[7]}} : 8'h00, r};
    if (op inside {OP_MUL_U, OP_MUL_S, OP_MUL_SU, OP_MUL_FRAC})
    begin
      p = (op == OP_MUL_FRAC) ? m << 1 : m;
      f.c = m[15];
      f.z = (p == 16'h0000);
    end
    if (op == OP_ONES)
      lo = 8'hff;
  endtask

  // ==========================================================
  // One operation through the bus, then every result place
  // ==========================================================
  task automatic run(input bal_op_t op, input logic [7:0] d, r, k, h,
    input bal_flags_t fi);
    logic [7:0] lo;
    logic [7:0] ho;
    logic [15:0] p;
    bal_flags_t f;
    logic [5:0] fm;
    logic [31:0] v;
    int n;
    int cy;
    model(op, d, r, k, h, fi, lo, ho, p, f, fm);
    cy = (op inside {OP_WORD_ADD, OP_WORD_SUB, OP_MUL_U, OP_MUL_S,
      OP_MUL_SU, OP_MUL_FRAC}) ? 2 : 1;
    wr(OFS_DEST, {24'h0, d});
    wr(OFS_SRC, {24'h0, r});
    wr(OFS_IMM, {24'h0, k});
    wr(OFS_HIGH, {24'h0, h});
    wr(OFS_FLAGS, {26'h0, fi});
    wr(OFS_CMD, {27'h0, op});
    n = 0;
    @(negedge clk);
    while (busy === 1'b1 && n < 5)
    begin
      n++;
      @(negedge clk);
    end
    chk("cycles", n, cy);
    u_bal_host.rd(OFS_DEST, v);
    chk("dest", v, {24'h0, lo});
    u_bal_host.rd(OFS_HIGH, v);
    chk("high", v, {24'h0, ho});
    u_bal_host.rd(OFS_FLAGS, v);
    chk("flags", v & {26'h0, fm}, {26'h0, f & fm});
    u_bal_host.rd(OFS_PROD, v);
    chk("prod", v, {16'h0, p});
    chk("flag pins", {24'h0, flags & {2'b0, fm}}, {26'h0, f & fm});
    exp_prod = p;
    $display("test op %h done", op);
  endtask

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial
  begin
    logic [31:0] v;
    int n;
    rst = 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      u_bal_host.rd(5'(i * 4), v);
      chk("reset value", v, 32'h0);
    end
    chk("reset pins", {23'h0, busy, flags}, 32'h0);
    u_bal_host.rd(5'h01, v);
    chk("unmapped read", v, 32'h0);
    u_bal_host.wr(5'h01, 32'h5a, 4'h1, n);
    u_bal_host.wr(OFS_DEST, 32'h77, 4'h0, n);
    u_bal_host.wr(OFS_CMD, {27'h0, OP_ONES}, 4'h0, n);
    u_bal_host.rd(OFS_DEST, v);
    chk("ignored writes", v, 32'h0);
    $display("test access done");
    run(OP_SUM, 8'h0f, 8'h01, 8'h00, 8'h00, 6'h00);
    run(OP_SUM, 8'h80, 8'h80, 8'h00, 8'h00, 6'h10);
    run(OP_SUM_C, 8'h7f, 8'h00, 8'h00, 8'h00, 6'h01);
    run(OP_DIFF, 8'h00, 8'h01, 8'h00, 8'h00, 6'h00);
    run(OP_DIFF_IMM, 8'h80, 8'h00, 8'h01, 8'h00, 6'h00);
    run(OP_DIFF_B, 8'h05, 8'h05, 8'h00, 8'h00, 6'h01);
    run(OP_DIFF_B_IMM, 8'h10, 8'h00, 8'h0f, 8'h00, 6'h01);
    run(OP_WORD_ADD, 8'hff, 8'h00, 8'h01, 8'h7f, 6'h00);
    run(OP_WORD_ADD, 8'hc1, 8'h00, 8'h3f, 8'hff, 6'h00);
    run(OP_WORD_SUB, 8'h00, 8'h00, 8'h01, 8'h00, 6'h00);
    run(OP_WORD_SUB, 8'h00, 8'h00, 8'h01, 8'h80, 6'h00);
    run(OP_AND, 8'hf0, 8'h0f, 8'h00, 8'h00, 6'h3f);
    run(OP_AND_IMM, 8'hf0, 8'h00, 8'hc3, 8'h00, 6'h08);
    run(OP_OR, 8'h00, 8'h00, 8'h00, 8'h00, 6'h00);
    run(OP_OR_IMM, 8'h01, 8'h00, 8'h80, 8'h00, 6'h08);
    run(OP_XOR, 8'haa, 8'hff, 8'h00, 8'h00, 6'h00);
    run(OP_INVERT, 8'h00, 8'h00, 8'h00, 8'h00, 6'h00);
    run(OP_NEGATE, 8'h80, 8'h00, 8'h00, 8'h00, 6'h00);
    run(OP_NEGATE, 8'h00, 8'h00, 8'h00, 8'h00, 6'h3f);
    run(OP_NEGATE, 8'h01, 8'h00, 8'h00, 8'h00, 6'h00);
    run(OP_SET_MASK, 8'h01, 8'h00, 8'h80, 8'h00, 6'h00);
    run(OP_CLR_MASK, 8'hff, 8'h00, 8'h0f, 8'h00, 6'h08);
    run(OP_PLUS1, 8'h7f, 8'h00, 8'h00, 8'h00, 6'h01);
    run(OP_PLUS1, 8'hff, 8'h00, 8'h00, 8'h00, 6'h00);
    run(OP_MINUS1, 8'h80, 8'h00, 8'h00, 8'h00, 6'h21);
    run(OP_MINUS1, 8'h00, 8'h00, 8'h00, 8'h00, 6'h00);
    run(OP_CHECK, 8'h80, 8'h00, 8'h00, 8'h00, 6'h08);
    run(OP_ZERO, 8'h5a, 8'h00, 8'h00, 8'h00, 6'h3d);
    run(OP_ONES, 8'h12, 8'h00, 8'h00, 8'h00, 6'h2a);
    run(OP_MUL_U, 8'hff, 8'hff, 8'h00, 8'h00, 6'h00);
    run(OP_MUL_U, 8'h00, 8'h05, 8'h00, 8'h00, 6'h01);
    run(OP_MUL_S, 8'h80, 8'hff, 8'h00, 8'h00, 6'h00);
    run(OP_MUL_S, 8'h80, 8'h7f, 8'h00, 8'h00, 6'h00);
    run(OP_MUL_SU, 8'hff, 8'hff, 8'h00, 8'h00, 6'h00);
    run(OP_MUL_FRAC, 8'hc0, 8'h80, 8'h00, 8'h00, 6'h01);
    run(OP_MUL_FRAC, 8'hff, 8'hff, 8'h00, 8'h00, 6'h00);
    run(bal_op_t'(5'h1f), 8'h33, 8'h44, 8'h55, 8'h66, 6'h15);
    // A write behind a two-cycle product waits; the product keeps old SRC
    wr(OFS_DEST, 32'h03);
    wr(OFS_SRC, 32'h05);
    u_bal_host.wr(OFS_CMD, {27'h0, OP_MUL_U}, 4'h1, n);
    u_bal_host.wr(OFS_SRC, 32'h09, 4'h1, n);
    chk("stall edges", n, 2);
    u_bal_host.rd(OFS_PROD, v);
    chk("stalled prod", v, 32'h0f);
    u_bal_host.wr(OFS_CMD, {27'h0, OP_PLUS1}, 4'h1, n);
    u_bal_host.wr(OFS_CMD, {27'h0, OP_PLUS1}, 4'h1, n);
    chk("no stall", n, 1);
    u_bal_host.rd(OFS_DEST, v);
    chk("back to back", v, 32'h05);
    $display("test stall done");
    wrap_up();
  end
endmodule
